// ---- core/dma_channel_register_set.sv ----
// Eight-channel transfer controller register set with its word FIFO and RAM write engine.
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "xfer_defs.svh"

// ==========================================================================
// Word FIFO
// ==========================================================================
module word_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] level_ff;
   logic push;
   logic pop;

   assign in_ready_out = (level_ff != (AW+1)'(DEPTH));
   assign out_valid_out = (level_ff != '0);
   assign out_data_out = mem_ff[rd_ptr_ff];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         level_ff <= level_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : word_fifo

module dma_channel_register_set (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Avalon-MM slave
   input wire logic [`XFER_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Peripheral word stream
   input wire logic periph_valid_in,
   input wire xfer_pkg::chan_t periph_chan_in,
   input wire xfer_pkg::word_t periph_data_in,
   output logic periph_ready_out,
   input wire logic [7:0] periph_collision_in,
   // RAM write port
   output logic ram_we_out,
   output xfer_pkg::word_t ram_addr_out,
   output xfer_pkg::word_t ram_wdata_out,
   input wire logic ram_ready_in,
   input wire logic ram_collision_in,
   // Interrupt controller side
   output logic [7:0] chan_irq_out,
   output logic [6:0] irq_vector_out,
   output logic [23:0] pri_table_addr_out,
   output logic [23:0] alt_table_addr_out
);
   import xfer_pkg::*;

   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic word_t merge_be(input word_t old, input logic [31:0] wd,
                                      input logic [3:0] be);
      word_t res;
      res = old;
      if (be[0]) begin
         res[7:0] = wd[7:0];
      end
      if (be[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction : merge_be

   // Only channels five to seven have known vectors; the rest report none.
   function automatic logic [6:0] vec_of(input chan_t ch);
      case (ch)
         3'h5: vec_of = `XFER_VEC_CH5;
         3'h6: vec_of = `XFER_VEC_CH6;
         3'h7: vec_of = `XFER_VEC_CH7;
         default: vec_of = `XFER_VEC_NONE;
      endcase
   endfunction : vec_of

   function automatic logic [23:0] table_of(input chan_t ch, input logic alt);
      case (ch)
         3'h5: table_of = alt ? `XFER_ATAB_CH5 : `XFER_PTAB_CH5;
         3'h6: table_of = alt ? `XFER_ATAB_CH6 : `XFER_PTAB_CH6;
         3'h7: table_of = alt ? `XFER_ATAB_CH7 : `XFER_PTAB_CH7;
         default: table_of = `XFER_TAB_NONE;
      endcase
   endfunction : table_of

   // ==========================================================================
   // Storage
   // ==========================================================================
   word_t ctl_ff [8];
   word_t req_sel_ff [8];
   word_t sta_ff [8];
   word_t stb_ff [8];
   word_t pad_ff [8];
   count_t cnt_ff [8];
   word_t ptr_ff [8];
   count_t done_ff [8];
   logic [7:0] pp_sel_ff;
   logic [7:0] ram_col_ff;
   logic [7:0] per_col_ff;
   logic [3:0] last_chan_ff;
   bus_state_e bus_state_ff;
   logic [31:0] rdata_ff;
   logic [7:0] irq_ff;
   logic [6:0] vec_ff;
   logic [23:0] ptab_ff;
   logic [23:0] atab_ff;

   // ==========================================================================
   // Bus decode
   // ==========================================================================
   logic req;
   logic wr_take;
   logic shared_hit;
   chan_t bus_ch;
   logic [2:0] bus_reg;
   logic chan_hit;

   assign req = avs_read_in || avs_write_in;
   assign shared_hit = avs_address_in[8];
   assign bus_ch = avs_address_in[7:5];
   assign bus_reg = avs_address_in[4:2];
   assign chan_hit = !avs_address_in[9] && !shared_hit;
   assign avs_waitrequest_out = req && (bus_state_ff != BUS_ACK);
   assign wr_take = avs_write_in && (bus_state_ff == BUS_ACK);
   assign avs_readdata_out = rdata_ff;

   // One wait cycle: the request is seen, read data is registered, then acknowledged.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         bus_state_ff <= BUS_IDLE;
      end else begin
         case (bus_state_ff)
            BUS_IDLE: bus_state_ff <= req ? BUS_ACK : BUS_IDLE;
            BUS_ACK: bus_state_ff <= BUS_IDLE;
            default: bus_state_ff <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_ff <= 32'h00000000;
      end else if (avs_read_in && bus_state_ff == BUS_IDLE) begin
         rdata_ff <= 32'h00000000;
         if (avs_address_in == `XFER_OFS_COLLISION) begin
            rdata_ff[15:0] <= {ram_col_ff, per_col_ff};
         end else if (avs_address_in == `XFER_OFS_PINGPONG) begin
            rdata_ff[15:0] <= {4'h0, last_chan_ff, pp_sel_ff};
         end else if (chan_hit) begin
            case (bus_reg)
               `XFER_OFS_CONTROL: rdata_ff[15:0] <= ctl_ff[bus_ch];
               `XFER_OFS_REQ_SEL: rdata_ff[15:0] <= req_sel_ff[bus_ch];
               `XFER_OFS_PRI_START: rdata_ff[15:0] <= ptr_ff[bus_ch];
               `XFER_OFS_SEC_START: rdata_ff[15:0] <= ptr_ff[bus_ch];
               `XFER_OFS_PERIPH_ADDR: rdata_ff[15:0] <= pad_ff[bus_ch];
               `XFER_OFS_COUNT: rdata_ff[9:0] <= cnt_ff[bus_ch];
               default: rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================================
   // Transfer engine
   // ==========================================================================
   logic [18:0] head;
   logic head_valid;
   chan_t eng_ch;
   logic eng_en;
   logic pop;
   logic word_done;
   logic blk_end;
   logic [7:0] start_vec;
   word_t ctl_wr;
   word_t cnt_wr;

   assign eng_ch = head[18:16];
   assign eng_en = ctl_ff[eng_ch][`XFER_CTL_ENABLE_BIT];
   assign ram_we_out = head_valid && eng_en;
   assign ram_addr_out = ptr_ff[eng_ch];
   assign ram_wdata_out = head[15:0];
   // Words for a disabled channel are dropped so one idle channel cannot block the rest.
   assign pop = head_valid && (!eng_en || ram_ready_in);
   assign word_done = ram_we_out && ram_ready_in;
   assign blk_end = word_done && (done_ff[eng_ch] == cnt_ff[eng_ch]);
   assign ctl_wr = merge_be(ctl_ff[bus_ch], avs_writedata_in, avs_byteenable_in);
   assign cnt_wr = merge_be({6'h00, cnt_ff[bus_ch]}, avs_writedata_in, avs_byteenable_in);

   word_fifo #(
      .WIDTH(19),
      .DEPTH(8)
   ) u_fifo (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(periph_valid_in),
      .in_data_in({periph_chan_in, periph_data_in}),
      .in_ready_out(periph_ready_out),
      .out_valid_out(head_valid),
      .out_data_out(head),
      .out_ready_in(pop)
   );

   always_comb begin
      start_vec = 8'h00;
      if (wr_take && chan_hit && bus_reg == `XFER_OFS_CONTROL) begin
         start_vec[bus_ch] = ctl_wr[`XFER_CTL_ENABLE_BIT] &&
                             !ctl_ff[bus_ch][`XFER_CTL_ENABLE_BIT];
      end
   end

   // Register writes; a one-shot channel drops its enable when its block ends.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < 8; i++) begin
            ctl_ff[i] <= `XFER_RESET_16;
            req_sel_ff[i] <= `XFER_RESET_16;
            sta_ff[i] <= `XFER_RESET_16;
            stb_ff[i] <= `XFER_RESET_16;
            pad_ff[i] <= `XFER_RESET_16;
            cnt_ff[i] <= `XFER_RESET_10;
         end
      end else begin
         if (blk_end && ctl_ff[eng_ch][`XFER_CTL_ONESHOT_BIT]) begin
            ctl_ff[eng_ch][`XFER_CTL_ENABLE_BIT] <= 1'b0;
         end
         if (wr_take && chan_hit) begin
            case (bus_reg)
               `XFER_OFS_CONTROL: ctl_ff[bus_ch] <= ctl_wr;
               `XFER_OFS_REQ_SEL: begin
                  req_sel_ff[bus_ch] <= merge_be(req_sel_ff[bus_ch], avs_writedata_in,
                                                 avs_byteenable_in);
               end
               `XFER_OFS_PRI_START: begin
                  sta_ff[bus_ch] <= merge_be(sta_ff[bus_ch], avs_writedata_in,
                                             avs_byteenable_in);
               end
               `XFER_OFS_SEC_START: begin
                  stb_ff[bus_ch] <= merge_be(stb_ff[bus_ch], avs_writedata_in,
                                             avs_byteenable_in);
               end
               `XFER_OFS_PERIPH_ADDR: begin
                  pad_ff[bus_ch] <= merge_be(pad_ff[bus_ch], avs_writedata_in,
                                             avs_byteenable_in);
               end
               `XFER_OFS_COUNT: begin
                  cnt_ff[bus_ch] <= cnt_wr[9:0];
               end
               default: ;
            endcase
         end
      end
   end

   // Pointer walk: load on enable, step per word, reload from the next buffer at block end.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < 8; i++) begin
            ptr_ff[i] <= `XFER_RESET_16;
            done_ff[i] <= `XFER_RESET_10;
         end
         pp_sel_ff <= 8'h00;
      end else begin
         if (word_done) begin
            if (blk_end) begin
               done_ff[eng_ch] <= `XFER_RESET_10;
               if (ctl_ff[eng_ch][`XFER_CTL_PINGPONG_BIT] && !pp_sel_ff[eng_ch]) begin
                  pp_sel_ff[eng_ch] <= 1'b1;
                  ptr_ff[eng_ch] <= stb_ff[eng_ch];
               end else begin
                  pp_sel_ff[eng_ch] <= 1'b0;
                  ptr_ff[eng_ch] <= sta_ff[eng_ch];
               end
            end else begin
               done_ff[eng_ch] <= done_ff[eng_ch] + 10'h001;
               ptr_ff[eng_ch] <= ptr_ff[eng_ch] + `XFER_PTR_STEP;
            end
         end
         for (int i = 0; i < 8; i++) begin
            if (start_vec[i]) begin
               ptr_ff[i] <= sta_ff[i];
               done_ff[i] <= `XFER_RESET_10;
               pp_sel_ff[i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================================
   // Status flags
   // ==========================================================================
   logic col_clr;
   assign col_clr = wr_take && avs_address_in == `XFER_OFS_COLLISION;

   // Write one to clear; a collision in the same cycle keeps its flag set.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ram_col_ff <= 8'h00;
         per_col_ff <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (word_done && ram_collision_in && eng_ch == chan_t'(i)) begin
               ram_col_ff[i] <= 1'b1;
            end else if (col_clr && avs_byteenable_in[1] && avs_writedata_in[8 + i]) begin
               ram_col_ff[i] <= 1'b0;
            end
            if (periph_collision_in[i]) begin
               per_col_ff[i] <= 1'b1;
            end else if (col_clr && avs_byteenable_in[0] && avs_writedata_in[i]) begin
               per_col_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         last_chan_ff <= 4'hF;
      end else if (word_done) begin
         last_chan_ff <= {1'b0, eng_ch};
      end
   end

   // ==========================================================================
   // Interrupt controller side
   // ==========================================================================
   // The request pulse, vector and table addresses leave here; flag, enable and priority are kept outside.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         irq_ff <= 8'h00;
         vec_ff <= `XFER_VEC_NONE;
         ptab_ff <= `XFER_TAB_NONE;
         atab_ff <= `XFER_TAB_NONE;
      end else begin
         irq_ff <= 8'h00;
         if (blk_end) begin
            irq_ff[eng_ch] <= 1'b1;
            vec_ff <= vec_of(eng_ch);
            ptab_ff <= table_of(eng_ch, 1'b0);
            atab_ff <= table_of(eng_ch, 1'b1);
         end
      end
   end

   assign chan_irq_out = irq_ff;
   assign irq_vector_out = vec_ff;
   assign pri_table_addr_out = ptab_ff;
   assign alt_table_addr_out = atab_ff;
endmodule : dma_channel_register_set

// ---- core/xfer_defs.svh ----
// Register offsets, field positions, reset values and vector figures of the channel register set.
`ifndef XFER_DEFS_SVH
`define XFER_DEFS_SVH

// ==========================================================================
// Bus map
// ==========================================================================
`define XFER_ADDR_W 10
`define XFER_CHAN_STRIDE 10'h020
`define XFER_OFS_CONTROL 3'h0
`define XFER_OFS_REQ_SEL 3'h1
`define XFER_OFS_PRI_START 3'h2
`define XFER_OFS_SEC_START 3'h3
`define XFER_OFS_PERIPH_ADDR 3'h4
`define XFER_OFS_COUNT 3'h5
`define XFER_OFS_COLLISION 10'h100
`define XFER_OFS_PINGPONG 10'h104

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define XFER_CTL_ENABLE_BIT 15
`define XFER_CTL_ONESHOT_BIT 1
`define XFER_CTL_PINGPONG_BIT 0
`define XFER_RESET_16 16'h0000
`define XFER_RESET_10 10'h000
`define XFER_PTR_STEP 16'h0002

// ==========================================================================
// Interrupt vectors
// ==========================================================================
`define XFER_VEC_CH5 7'h45
`define XFER_VEC_CH6 7'h4C
`define XFER_VEC_CH7 7'h4D
`define XFER_VEC_NONE 7'h00
`define XFER_PTAB_CH5 24'h00008E
`define XFER_PTAB_CH6 24'h00009C
`define XFER_PTAB_CH7 24'h00009E
`define XFER_ATAB_CH5 24'h00018E
`define XFER_ATAB_CH6 24'h00019C
`define XFER_ATAB_CH7 24'h00019E
`define XFER_TAB_NONE 24'h000000

`endif

// ---- core/xfer_pkg.sv ----
// Types shared by the channel register set.
package xfer_pkg;
   typedef logic [15:0] word_t;
   typedef logic [9:0] count_t;
   typedef logic [2:0] chan_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_e;
endpackage : xfer_pkg

// ---- sim/ram_model.sv ----
// Behavioural model of the data RAM write port behind the channel register set.
`timescale 1ns/1ns
module ram_model
   import xfer_pkg::*;
(
   // Clock
   input wire logic core_clk_in,
   // Write port from the block
   input wire logic ram_we_in,
   input wire xfer_pkg::word_t ram_addr_in,
   input wire xfer_pkg::word_t ram_wdata_in,
   output logic ram_ready_out,
   output logic ram_collision_out,
   // Commands from the bench
   input wire logic stall_in,
   input wire logic collide_in
);
   int wr_count = 0;
   word_t log_addr [64];
   word_t log_data [64];
   // A stalled RAM holds ready low so the block must keep its write standing.
   assign ram_ready_out = !stall_in;
   assign ram_collision_out = collide_in && ram_we_in;
   always @(posedge core_clk_in) begin
      if (ram_we_in && ram_ready_out) begin
         log_addr[wr_count] <= ram_addr_in;
         log_data[wr_count] <= ram_wdata_in;
         wr_count <= wr_count + 1;
      end
   end
endmodule : ram_model

// ---- sim/dma_regs_props.sv ----
// Concurrent checks on the ports of the channel register set.
`timescale 1ns/1ns
module dma_regs_checker (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Register bus
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // RAM and interrupt side
   input wire logic ram_we_out,
   input wire xfer_pkg::word_t ram_addr_out,
   input wire xfer_pkg::word_t ram_wdata_out,
   input wire logic ram_ready_in,
   input wire logic [7:0] chan_irq_out,
   input wire logic [6:0] irq_vector_out,
   input wire logic [23:0] pri_table_addr_out,
   input wire logic [23:0] alt_table_addr_out
);
   import xfer_pkg::*;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // ==========================================================================
   // Sequences
   // ==========================================================================
   sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
   sequence s_rd_ack; avs_read_in && !avs_waitrequest_out; endsequence
   // A CPU write may disable the channel, which lawfully withdraws the write.
   sequence s_stall; ram_we_out && !ram_ready_in && !avs_write_in; endsequence
   // ==========================================================================
   // Assertions
   // ==========================================================================
   AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest_out)
      else $error("bus request waited more than one cycle");
   AST_WAIT_FIRST: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
      else $error("read acknowledged without its wait cycle");
   AST_RDATA_HIGH: assert property (s_rd_ack |-> avs_readdata_out[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   AST_COUNT_WIDTH: assert property (s_rd_ack ##0 (!avs_address_in[9] &&
      avs_address_in[4:2] == 3'h5) |-> avs_readdata_out[15:10] == 6'h00)
      else $error("transfer count wider than ten bits");
   AST_UNMAPPED: assert property (s_rd_ack ##0 (!avs_address_in[8] &&
      avs_address_in[4:2] > 3'h5) |-> avs_readdata_out == 32'h0000_0000)
      else $error("unmapped read returned data");
   AST_RAM_HOLD: assert property (s_stall |=> ram_we_out && $stable(ram_addr_out) &&
      $stable(ram_wdata_out))
      else $error("RAM write changed while stalled");
   AST_IRQ_CAUSE: assert property (chan_irq_out != 8'h00 |->
      $past(ram_we_out && ram_ready_in) && $onehot(chan_irq_out))
      else $error("channel pulse without a completed word");
   AST_VEC_CH5: assert property (chan_irq_out[5] |-> irq_vector_out == 7'h45 &&
      pri_table_addr_out == 24'h00008E && alt_table_addr_out == 24'h00018E)
      else $error("channel five vector wrong");
   AST_VEC_CH6: assert property (chan_irq_out[6] |-> irq_vector_out == 7'h4C &&
      pri_table_addr_out == 24'h00009C && alt_table_addr_out == 24'h00019C)
      else $error("channel six vector wrong");
   AST_VEC_CH7: assert property (chan_irq_out[7] |-> irq_vector_out == 7'h4D &&
      pri_table_addr_out == 24'h00009E && alt_table_addr_out == 24'h00019E)
      else $error("channel seven vector wrong");
endmodule : dma_regs_checker

bind dma_channel_register_set dma_regs_checker u_chk (.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .ram_we_out(ram_we_out),
   .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out), .ram_ready_in(ram_ready_in),
   .chan_irq_out(chan_irq_out), .irq_vector_out(irq_vector_out),
   .pri_table_addr_out(pri_table_addr_out), .alt_table_addr_out(alt_table_addr_out));

// ---- sim/dma_channel_register_set_tb_top.sv ----
// Self-checking bench for the channel register set.
`timescale 1ns/1ns
module dma_channel_register_set_tb_top;
   import xfer_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [9:0] avs_address_in = 10'h000;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0000_0000;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out, periph_ready_out, ram_we_out, ram_ready_in, ram_collision_in;
   logic periph_valid_in = 1'b0;
   chan_t periph_chan_in = 3'h0;
   word_t periph_data_in = 16'h0000;
   logic [7:0] periph_collision_in = 8'h00;
   word_t ram_addr_out, ram_wdata_out;
   logic [7:0] chan_irq_out;
   logic [6:0] irq_vector_out;
   logic [23:0] pri_table_addr_out, alt_table_addr_out;
   logic stall = 1'b0;
   logic collide = 1'b0;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   always #25 core_clk_in = ~core_clk_in;
   dma_channel_register_set u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .periph_valid_in(periph_valid_in), .periph_chan_in(periph_chan_in),
      .periph_data_in(periph_data_in), .periph_ready_out(periph_ready_out),
      .periph_collision_in(periph_collision_in), .ram_we_out(ram_we_out),
      .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out), .ram_ready_in(ram_ready_in),
      .ram_collision_in(ram_collision_in), .chan_irq_out(chan_irq_out),
      .irq_vector_out(irq_vector_out), .pri_table_addr_out(pri_table_addr_out),
      .alt_table_addr_out(alt_table_addr_out));
   ram_model u_ram (.core_clk_in(core_clk_in), .ram_we_in(ram_we_out),
      .ram_addr_in(ram_addr_out), .ram_wdata_in(ram_wdata_out), .ram_ready_out(ram_ready_in),
      .ram_collision_out(ram_collision_in), .stall_in(stall), .collide_in(collide));
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask : chk
   // The request stands until the edge that samples waitrequest low.
   task automatic bus(input logic wr, input logic [9:0] a, input word_t d, output word_t q);
      @(posedge core_clk_in);
      avs_read_in <= !wr;
      avs_write_in <= wr;
      avs_address_in <= a;
      avs_writedata_in <= {16'h0000, d};
      do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out[15:0];
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus
   task automatic wr(input logic [9:0] a, input word_t d);
      word_t q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [9:0] a, input word_t exp);
      word_t q;
      bus(1'b0, a, 16'h0000, q);
      chk({16'h0000, q}, {16'h0000, exp});
   endtask : rd
   task automatic push(input chan_t c, input word_t d, output logic ok);
      @(posedge core_clk_in);
      periph_valid_in <= 1'b1;
      periph_chan_in <= c;
      periph_data_in <= d;
      ok = 1'b0;
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge core_clk_in);
         ok = (periph_ready_out === 1'b1);
      end
      periph_valid_in <= 1'b0;
   endtask : push
   task automatic wait_writes(input int n);
      while (u_ram.wr_count != n) @(posedge core_clk_in);
   endtask : wait_writes
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic test_storage;
      logic [9:0] b;
      rd(10'h000, 16'h0000);
      rd(10'h104, 16'h0F00);
      for (int c = 0; c < 8; c++) begin
         b = 10'(c * 32);
         wr(b, 16'h5A00 | 16'(c));
         wr(b + 10'h004, 16'hC300 | 16'(c));
         wr(b + 10'h010, 16'h1234 + 16'(c));
         wr(b + 10'h014, 16'hFFF0 | 16'(c));
      end
      for (int c = 0; c < 8; c++) begin
         b = 10'(c * 32);
         rd(b, 16'h5A00 | 16'(c));
         rd(b + 10'h004, 16'hC300 | 16'(c));
         rd(b + 10'h010, 16'h1234 + 16'(c));
         rd(b + 10'h014, 16'h03F0 | 16'(c));
      end
      wr(10'h018, 16'hBEEF);
      rd(10'h018, 16'h0000);
      rd(10'h200, 16'h0000);
      $display("test_storage done");
   endtask : test_storage
   task automatic test_pointer;
      logic ok;
      wr(10'h0A8, 16'h1000);
      wr(10'h0AC, 16'h2000);
      wr(10'h0B4, 16'h0001);
      wr(10'h0A0, 16'h8001);
      rd(10'h0A8, 16'h1000);
      rd(10'h0AC, 16'h1000);
      push(3'h5, 16'h1111, ok);
      wait_writes(1);
      rd(10'h0AC, 16'h1002);
      push(3'h5, 16'h2222, ok);
      wait_writes(2);
      rd(10'h0A8, 16'h2000);
      chk(u_ram.log_addr[1], 16'h1002);
      chk(u_ram.log_data[1], 16'h2222);
      rd(10'h104, 16'h0520);
      $display("test_pointer done");
   endtask : test_pointer
   task automatic test_vectors;
      logic ok;
      logic [9:0] b;
      logic [6:0] vec [4] = '{7'h00, 7'h45, 7'h4C, 7'h4D};
      logic [23:0] tab [4] = '{24'h000000, 24'h00008E, 24'h00009C, 24'h00009E};
      for (int c = 4; c < 8; c++) begin
         b = 10'(c * 32);
         wr(b, 16'h0000);
         wr(b + 10'h008, 16'h4000 | 16'(c * 256));
         wr(b + 10'h014, 16'h0000);
         wr(b, 16'h8000);
         push(3'(c), 16'h7700, ok);
         wait_writes(c - 1);
         chk(chan_irq_out, 32'h1 << c);
         repeat (2) @(posedge core_clk_in);
         chk(irq_vector_out, vec[c - 4]);
         chk(pri_table_addr_out, tab[c - 4]);
         chk(alt_table_addr_out, (c == 4) ? 24'h000000 : tab[c - 4] + 24'h000100);
      end
      $display("test_vectors done");
   endtask : test_vectors
   task automatic test_fifo;
      logic ok;
      int acc;
      acc = 0;
      wr(10'h068, 16'h3000);
      wr(10'h074, 16'h03FF);
      wr(10'h060, 16'h8000);
      stall <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         push(3'h3, 16'hD000 + 16'(i), ok);
         if (ok) acc++;
      end
      chk(acc, 8);
      collide <= 1'b1;
      stall <= 1'b0;
      periph_collision_in <= 8'h04;
      @(posedge core_clk_in);
      periph_collision_in <= 8'h00;
      wait_writes(14);
      collide <= 1'b0;
      chk(u_ram.log_addr[13], 16'h300E);
      rd(10'h068, 16'h3010);
      rd(10'h100, 16'h0804);
      wr(10'h100, 16'h0804);
      rd(10'h100, 16'h0000);
      // A word for a disabled channel is consumed without a RAM write.
      push(3'h0, 16'hEEEE, ok);
      repeat (6) @(posedge core_clk_in);
      chk(u_ram.wr_count, 14);
      $display("test_fifo done");
   endtask : test_fifo
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      repeat (12) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(posedge core_clk_in);
      test_storage();
      test_pointer();
      test_vectors();
      test_fifo();
      final_report();
   end
endmodule : dma_channel_register_set_tb_top
